// ===== rtl/frps_regs.svh
// Register offsets, field positions, key values, operation codes and timing counts of the flash sequencer
`ifndef FRPS_REGS_SVH
`define FRPS_REGS_SVH
`define FRPS_OFF_CONTROL 4'h0
`define FRPS_OFF_KEY 4'h1
`define FRPS_OFF_TBL_PAGE 4'h2
`define FRPS_OFF_TBL_ADDR 4'h3
`define FRPS_OFF_TBL_LOW 4'h4
`define FRPS_OFF_TBL_HIGH 4'h5
`define FRPS_OFF_STATUS 4'h6
`define FRPS_BIT_GO 15
`define FRPS_BIT_WRITE_ENABLE_BIT 14
`define FRPS_BIT_ERR 13
`define FRPS_BIT_ERASE 6
`define FRPS_KEY_FIRST 8'h55
`define FRPS_KEY_SECOND 8'haa
`define FRPS_OP_PAGE_ERASE 4'h2
`define FRPS_OP_ROW_PROG 4'h1
`define FRPS_OP_WORD_PROG 4'h3
`define FRPS_OP_CFG_BYTE 4'h0
`define FRPS_OP_BULK_ERASE 4'hf
`define FRPS_OP_GEN_ERASE 4'hd
`define FRPS_OP_SEC_ERASE 4'hc
`define FRPS_PROG_TIME_NS 4000000
`define FRPS_CLK_NS 50
`define FRPS_PROG_CYCLES (`FRPS_PROG_TIME_NS / `FRPS_CLK_NS)
`endif

// ===== rtl/frps_pkg.sv
// Types shared by the flash sequencer
package frps_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} frps_state_e;
  typedef enum logic [1:0] {KEY_NONE, KEY_FIRST, KEY_OPEN} frps_key_e;
  typedef struct packed {
    logic go;
    logic write_enable_bit;
    logic err;
    logic erase;
    logic [3:0] op;
  } frps_ctrl_s;
  typedef struct packed {
    logic start;
    logic erase;
    logic [3:0] op;
    logic [23:0] addr;
  } frps_cmd_s;
endpackage

// ===== rtl/frps_latch.sv
// Row holding buffer of 24-bit instruction latches
`timescale 1ns/1ps
`default_nettype none
module frps_latch #(
  parameter int DEPTH = 64
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic wr_low, // Low word write strobe
  input wire logic wr_high, // High byte write strobe
  input wire logic [$clog2(DEPTH)-1:0] idx, // Entry index
  input wire logic [15:0] wdata, // Write data
  input wire logic [$clog2(DEPTH)-1:0] rd_idx, // Read index
  output logic [23:0] rdata // Entry read back
);
  logic [23:0] mem_q [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk)
      begin
        if (srst)
          mem_q[g] <= 24'hffffff;
        else if (wr_low && idx == g)
          mem_q[g][15:0] <= wdata;
        else if (wr_high && idx == g)
          mem_q[g][23:16] <= wdata[7:0];
      end
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    rdata <= mem_q[rd_idx];
  end
endmodule
`default_nettype wire

// ===== rtl/frps_top.sv
// Self-programming sequencer for on-chip program flash with Avalon-MM registers
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "frps_regs.svh"
module frps_top #(
  parameter int PROG_CYCLES = `FRPS_PROG_CYCLES,
  parameter int ROW_WORDS = 64
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic srst, // System reset, does not touch control bits
  input wire logic por, // Power-on reset, synchronous, active high
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall request
  output logic cpu_stall, // CPU held while flash cycle runs
  output frps_pkg::frps_cmd_s flash_cmd, // Operation handed to the array
  output logic [23:0] flash_wdata // Latch word being written
);
  localparam int IW = $clog2(ROW_WORDS);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    frps_pkg::frps_ctrl_s ctrl;
    frps_pkg::frps_key_e key;
    frps_pkg::frps_state_e st;
    logic [CW-1:0] cnt;
    logic [7:0] page;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic rack;
    frps_pkg::frps_cmd_s cmd;
  } frps_state_s;

  frps_state_s s_q, s_d;
  logic [23:0] latch_rd;

  // Codes that start a cycle for each erase setting
  function automatic logic op_valid(input logic erase, input logic [3:0] op);
    if (erase)
      return op == `FRPS_OP_PAGE_ERASE || op == `FRPS_OP_BULK_ERASE ||
             op == `FRPS_OP_GEN_ERASE || op == `FRPS_OP_SEC_ERASE ||
             op == `FRPS_OP_CFG_BYTE;
    else
      return op == `FRPS_OP_ROW_PROG || op == `FRPS_OP_WORD_PROG ||
             op == `FRPS_OP_CFG_BYTE;
  endfunction

  logic wr_ctl;
  logic wr_key;
  logic wr_low;
  logic wr_high;
  logic wr_page;
  logic wr_addr;
  assign wr_ctl = avs_write && avs_address == `FRPS_OFF_CONTROL;
  assign wr_key = avs_write && avs_address == `FRPS_OFF_KEY;
  assign wr_low = avs_write && avs_address == `FRPS_OFF_TBL_LOW;
  assign wr_high = avs_write && avs_address == `FRPS_OFF_TBL_HIGH;
  assign wr_page = avs_write && avs_address == `FRPS_OFF_TBL_PAGE;
  assign wr_addr = avs_write && avs_address == `FRPS_OFF_TBL_ADDR;

  // Read index follows the next pointer, so status shows a new entry at once
  frps_latch #(
    .DEPTH(ROW_WORDS)
  ) u_latch (
    .clk(clk),
    .srst(srst),
    .wr_low(wr_low),
    .wr_high(wr_high),
    .idx(s_q.addr[IW:1]),
    .wdata(avs_writedata[15:0]),
    .rd_idx(s_d.addr[IW:1]),
    .rdata(latch_rd)
  );

  always_comb
  begin
    logic [15:0] ctl_rd;
    ctl_rd = '0;
    s_d = s_q;
    s_d.rack = 1'b0;
    s_d.cmd.start = 1'b0;
    ctl_rd[`FRPS_BIT_GO] = s_q.ctrl.go;
    ctl_rd[`FRPS_BIT_WRITE_ENABLE_BIT] = s_q.ctrl.write_enable_bit;
    ctl_rd[`FRPS_BIT_ERR] = s_q.ctrl.err;
    ctl_rd[`FRPS_BIT_ERASE] = s_q.ctrl.erase;
    ctl_rd[3:0] = s_q.ctrl.op;
    // Read data registered, answered one cycle after request
    if (avs_read && !s_q.rack)
    begin
      s_d.rack = 1'b1;
      case (avs_address)
        `FRPS_OFF_CONTROL: s_d.rdata = {16'h0000, ctl_rd};
        `FRPS_OFF_TBL_PAGE: s_d.rdata = {24'h000000, s_q.page};
        `FRPS_OFF_TBL_ADDR: s_d.rdata = {16'h0000, s_q.addr};
        `FRPS_OFF_STATUS: s_d.rdata = {8'h00, latch_rd};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Unlock is spent by any write other than a key write
    if (avs_write && !wr_key)
      s_d.key = frps_pkg::KEY_NONE;
    if (wr_key)
    begin
      if (avs_writedata[7:0] == `FRPS_KEY_FIRST)
        s_d.key = frps_pkg::KEY_FIRST;
      else if (avs_writedata[7:0] == `FRPS_KEY_SECOND && s_q.key == frps_pkg::KEY_FIRST)
        s_d.key = frps_pkg::KEY_OPEN;
      else
        s_d.key = frps_pkg::KEY_NONE;
    end
    if (wr_page)
      s_d.page = avs_writedata[7:0];
    if (wr_addr)
      s_d.addr = avs_writedata[15:0];
    if (wr_high)
      s_d.addr = s_q.addr + 16'h0002;
    // Error set by a refused go wins over a clear in the same write
    if (wr_ctl)
    begin
      s_d.ctrl.write_enable_bit = avs_writedata[`FRPS_BIT_WRITE_ENABLE_BIT];
      if (!s_q.ctrl.go)
      begin
        s_d.ctrl.erase = avs_writedata[`FRPS_BIT_ERASE];
        s_d.ctrl.op = avs_writedata[3:0];
      end
      if (!avs_writedata[`FRPS_BIT_ERR])
        s_d.ctrl.err = 1'b0;
      if (avs_writedata[`FRPS_BIT_GO] && !s_q.ctrl.go)
      begin
        if (s_q.key == frps_pkg::KEY_OPEN && avs_writedata[`FRPS_BIT_WRITE_ENABLE_BIT] &&
            op_valid(s_q.ctrl.erase, s_q.ctrl.op))
        begin
          s_d.ctrl.go = 1'b1;
          s_d.cmd.start = 1'b1;
          s_d.cmd.erase = s_q.ctrl.erase;
          s_d.cmd.op = s_q.ctrl.op;
          s_d.cmd.addr = {s_q.page, s_q.addr};
        end
        else
          s_d.ctrl.err = 1'b1;
      end
    end
    // Self-timed cycle; go drops and error clears at the end
    case (s_q.st)
      frps_pkg::ST_IDLE:
      begin
        if (s_d.ctrl.go)
        begin
          s_d.st = frps_pkg::ST_BUSY;
          s_d.cnt = CW'(PROG_CYCLES - 1);
        end
      end
      frps_pkg::ST_BUSY:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.st = frps_pkg::ST_IDLE;
          s_d.ctrl.go = 1'b0;
          s_d.ctrl.err = 1'b0;
        end
        else
          s_d.cnt = s_q.cnt - CW'(1);
      end
      default: s_d.st = frps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (por)
      s_q <= '0;
    else if (srst)
    begin
      // System reset spares control bits and a running cycle
      s_q.key <= frps_pkg::KEY_NONE;
      s_q.rack <= 1'b0;
      s_q.cmd.start <= 1'b0;
      s_q.st <= s_d.st;
      s_q.cnt <= s_d.cnt;
      s_q.ctrl <= s_d.ctrl;
      s_q.page <= '0;
      s_q.addr <= '0;
      s_q.rdata <= '0;
      s_q.cmd.erase <= s_q.cmd.erase;
      s_q.cmd.op <= s_q.cmd.op;
      s_q.cmd.addr <= s_q.cmd.addr;
    end
    else
      s_q <= s_d;
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = avs_read && !s_q.rack;
  assign cpu_stall = s_q.ctrl.go;
  assign flash_cmd = s_q.cmd;
  assign flash_wdata = latch_rd;
endmodule
`default_nettype wire

// ===== test/frps_top_sva.sv
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module frps_top_sva #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic por, // Power-on reset
  input wire logic [3:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Wait
  input wire logic cpu_stall, // Stall
  input wire frps_pkg::frps_cmd_s flash_cmd, // Command
  input wire logic [23:0] flash_wdata // Latch word
);
  int cnt_q;
  wire key_w = avs_write && avs_address == 4'h1;
  always_ff @(posedge clk) cnt_q <= cpu_stall ? cnt_q + 1 : 0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (por);
  a_start_key: assert property (
    flash_cmd.start |-> $past(avs_write && avs_address == 4'h0 && avs_writedata[15])
    && $past(key_w && avs_writedata[7:0] == 8'haa, 2)
    && $past(key_w && avs_writedata[7:0] == 8'h55, 3)) else $error("Start without unlock");
  a_cycle_len: assert property ($fell(cpu_stall) |-> cnt_q == PROG_CYCLES)
    else $error("Cycle length wrong");
  a_start_rise: assert property (flash_cmd.start == $rose(cpu_stall))
    else $error("Start and stall disagree");
  a_op_cmd: assert property (
    flash_cmd.start |-> {flash_cmd.erase, flash_cmd.op}
    == $past({avs_writedata[6], avs_writedata[3:0]})) else $error("Wrong operation");
  a_op_locked: assert property (
    cpu_stall && $past(cpu_stall) |-> $stable({flash_cmd.erase, flash_cmd.op}))
    else $error("Operation changed while busy");
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Read wait wrong");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("Write held");
  a_por_clear: assert property ($fell(por) |-> !cpu_stall && avs_readdata == 32'h0)
    else $error("Power-on reset left state");
  c_start: cover property (flash_cmd.start);
  c_done: cover property ($fell(cpu_stall));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind frps_top frps_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk(clk), .srst(srst),
  .por(por), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .flash_wdata(flash_wdata),
  .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));
`default_nettype wire

// ===== test/frps_top_test.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module frps_top_test;
  logic clk = 1'b0, srst = 1'b1, por = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, cpu_stall;
  logic [23:0] flash_wdata;
  frps_pkg::frps_cmd_s flash_cmd;
  int fails = 0, n_tests = 0, cyc = 0;
  logic [16:0] ops [10] = '{17'h14042, 17'h1404f, 17'h1404d, 17'h1404c, 17'h14040,
    17'h14001, 17'h14003, 17'h14000, 17'h04043, 17'h0400f};
  frps_top #(.PROG_CYCLES(20)) uut (.clk(clk), .srst(srst), .por(por),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .flash_wdata(flash_wdata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));
  initial forever #25 clk = ~clk;
  task automatic wrap_up(input int hung);
    fails += hung;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 5000) wrap_up(1);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    fails += (got !== exp);
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [15:0] d,
    output logic [31:0] q);
    logic w;
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    do
    begin
      #1;
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
    end
    while (w !== 1'b0);
  endtask
  task automatic rel;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [16:0] e, input logic [15:0] mid);
    logic [31:0] q;
    int n = 0;
    bus(0, 4'h0, e[15:0], q);
    bus(0, 4'h1, 16'h55, q);
    bus(0, 4'h1, 16'haa, q);
    bus(0, 4'h0, e[15:0] | 16'h8000, q);
    rel();
    chk({31'h0, cpu_stall}, {31'h0, e[16]});
    if (mid != 16'h0)
      bus(0, 4'h0, mid, q);
    rel();
    while (cpu_stall === 1'b1 && n++ < 99)
      @(posedge clk);
    bus(1, 4'h0, 16'h0, q);
    rel();
    chk(q, {16'h0, e[16] ? e[15:0] : e[15:0] | 16'h2000});
    $display("Operation %h done", e[15:0]);
  endtask
  task automatic refuse(input logic cancel);
    logic [31:0] q;
    bus(0, 4'h0, 16'h4001, q);
    if (cancel)
    begin
      bus(0, 4'h1, 16'h55, q);
      bus(0, 4'h1, 16'haa, q);
      bus(0, 4'h2, 16'h0, q);
    end
    bus(0, 4'h0, 16'hc001, q);
    bus(1, 4'h0, 16'h0, q);
    rel();
    chk(q, 32'h6001);
    $display("Refusal done");
  endtask
  task automatic latch;
    logic [31:0] q;
    bus(0, 4'h3, 16'h2, q);
    bus(0, 4'h4, 16'h1234, q);
    bus(0, 4'h5, 16'h56, q);
    bus(0, 4'h3, 16'h2, q);
    bus(1, 4'h6, 16'h0, q);
    rel();
    chk(q, 32'h561234);
    chk({8'h0, flash_wdata}, 32'h561234);
    $display("Latch done");
  endtask
  // Page rewrite: erase the page, then load and program each row in turn
  task automatic page_rewrite;
    logic [31:0] q;
    logic [23:0] img [512];
    foreach (img[i])
      img[i] = {8'(i + 8'h30), 16'(i * 16'h0103)};
    bus(0, 4'h2, 16'h0001, q);
    bus(0, 4'h3, 16'h0400, q);
    op(17'h14042, 16'h0);
    chk({8'h00, flash_cmd.addr}, 32'h010400);
    for (int r = 0; r < 8; r++)
    begin
      bus(0, 4'h3, 16'h0400 + 16'(r * 128), q);
      for (int w = 0; w < 64; w++)
      begin
        bus(0, 4'h4, img[r * 64 + w][15:0], q);
        bus(0, 4'h5, {8'h00, img[r * 64 + w][23:16]}, q);
      end
      bus(0, 4'h3, 16'h0400 + 16'(r * 128 + 126), q);
      bus(1, 4'h6, 16'h0, q);
      chk(q, {8'h00, img[r * 64 + 63]});
      bus(0, 4'h3, 16'h0400 + 16'(r * 128), q);
      rel();
      chk({8'h00, flash_wdata}, {8'h00, img[r * 64]});
      op(17'h14001, 16'h0);
      chk({8'h00, flash_cmd.addr}, 32'h010400 + 32'(r * 128));
    end
    $display("Page rewrite done");
  endtask
  task automatic resets;
    logic [31:0] q;
    srst <= 1'b1;
    rel();
    srst <= 1'b0;
    bus(1, 4'h0, 16'h0, q);
    rel();
    chk(q, 32'h4001);
    por <= 1'b1;
    rel();
    por <= 1'b0;
    bus(1, 4'h0, 16'h0, q);
    rel();
    chk(q, 32'h0);
    $display("Resets done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    refuse(1'b0);
    refuse(1'b1);
    latch();
    foreach (ops[i])
      op(ops[i], 16'h0);
    op(17'h14001, 16'h404f);
    page_rewrite();
    resets();
    wrap_up(0);
  end
endmodule
`default_nettype wire
